// ---- regbank_pkg.sv ----
package regbank_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Printed register offsets
    localparam logic [5:0] OFS_CTRL_PRI = 6'h00;
    localparam logic [5:0] OFS_CTRL_SEC = 6'h04;
    localparam logic [5:0] OFS_BIT_RATE = 6'h0C;
    localparam logic [5:0] OFS_MASK_CLR = 6'h14;
    localparam logic [5:0] OFS_MASK_SET = 6'h16;
    localparam logic [5:0] OFS_PENDING = 6'h18;
    localparam logic [5:0] OFS_BUS_STATUS = 6'h1A;
    localparam logic [5:0] OFS_XDOM_PEND = 6'h1C;
    localparam logic [5:0] OFS_TGT_ADDR = 6'h24;
    localparam logic [5:0] OFS_XFER_DATA = 6'h28;
    localparam logic [5:0] OFS_HALT = 6'h30;

    ////////////////////////////////////////////////////////////////////////
    // Field positions of the primary control register
    localparam int SOFT_RESET_POS = 0;
    localparam int ENABLE_POS = 1;
    localparam int MODE_LSB = 2;
    localparam int MODE_W = 3;
    localparam logic [2:0] MODE_SLAVE = 3'h4;
    localparam logic [2:0] MODE_MASTER = 3'h5;
    localparam int RSV_TOP_POS = 31;

    // Bits of the cross-domain pending register
    localparam int PEND_SOFT_RESET = 0;
    localparam int PEND_ENABLE = 1;
    localparam int PEND_SYSOP = 2;

    // Bus state field inside the 16-bit status register
    localparam int BUS_STATE_LSB = 4;

    ////////////////////////////////////////////////////////////////////////
    // Writable bit masks, per operating mode where the two modes differ
    localparam logic [31:0] CTRL_PRI_SLAVE_MASK = 32'h4BB1_009F;
    localparam logic [31:0] CTRL_PRI_MASTER_MASK = 32'h7BF1_009F;
    localparam logic [31:0] CTRL_SEC_SLAVE_MASK = 32'h0004_C700;
    localparam logic [31:0] CTRL_SEC_MASTER_MASK = 32'h0004_0300;
    localparam logic [31:0] CTRL_SEC_FREE_MASK = 32'h0007_0000;
    localparam logic [31:0] CTRL_SEC_CMD_MASK = 32'h0003_0000;
    localparam logic [31:0] TGT_ADDR_SLAVE_MASK = 32'h07FE_87FF;
    localparam logic [31:0] TGT_ADDR_MASTER_MASK = 32'h00FF_E7FF;
    localparam logic [15:0] XFER_DATA_MASK = 16'h00FF;
    localparam logic [7:0] HALT_MASK = 8'h01;
    localparam logic [7:0] IRQ_SLAVE_MASK = 8'h87;
    localparam logic [7:0] IRQ_MASTER_MASK = 8'h83;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] CTRL_PRI_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_SEC_RESET = 32'h0000_0000;
    localparam logic [31:0] BIT_RATE_RESET = 32'h0000_0000;
    localparam logic [31:0] TGT_ADDR_RESET = 32'h0000_0000;
    localparam logic [15:0] XFER_DATA_RESET = 16'h0000;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [7:0] PENDING_RESET = 8'h00;
    localparam logic [1:0] BUS_STATE_RESET = 2'h0;
    localparam logic [7:0] HALT_RESET = 8'h00;

    // Core-side latency of a synchronised operation, in CLOCK cycles
    localparam int SYNC_CYCLES = 3;

endpackage

// ---- sync_tracker.sv ----
`timescale 1ns/1ns
module sync_tracker
    import regbank_pkg::*;
#(
    parameter int STAGES = SYNC_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    output logic busy,
    output logic done
);

    typedef struct packed {
        logic busy;
        logic [7:0] cnt;
    } track_s;

    track_s s_r;
    track_s s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Busy from the start until the core side has taken the operation
    always_comb
    begin
        s_nxt = s_r;
        if (start)
        begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt = 8'(STAGES - 1);
        end
        else if (s_r.busy)
        begin
            if (s_r.cnt == 8'h00)
                s_nxt.busy = 1'b0;
            else
                s_nxt.cnt = s_r.cnt - 8'h01;
        end
    end

    // Register stage, frozen while the clock enable is low
    always_ff @(posedge clk)
    begin
        if (rst)
            s_r <= '0;
        else if (ce)
            s_r <= s_nxt;
    end

    assign busy = s_r.busy;
    // Completion pulse in the last busy cycle
    assign done = s_r.busy && (s_r.cnt == 8'h00) && ce;

endmodule

// ---- regbank.sv ----
`timescale 1ns/1ns
module regbank
    import regbank_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [5:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic GUARD_PROTECT,
    input wire logic [7:0] FLAG_EVENTS,
    input wire logic [15:0] STATUS_IN,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic CORE_ENABLE,
    output logic [31:0] CONTROL_PRIMARY,
    output logic [31:0] CONTROL_SECONDARY,
    output logic [31:0] BIT_RATE,
    output logic [31:0] TARGET_ADDR,
    output logic [15:0] TX_DATA,
    output logic [7:0] IRQ_MASK,
    output logic [7:0] IRQ_PENDING,
    output logic HALT_STOP
);

    typedef struct packed {
        logic [31:0] ctrl_pri;
        logic [31:0] ctrl_sec;
        logic [31:0] bit_rate;
        logic [31:0] tgt_addr;
        logic [15:0] xfer_data;
        logic [7:0] irq_mask;
        logic [7:0] pending;
        logic [1:0] bus_state;
        logic [7:0] halt;
        logic core_en;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } bank_s;

    bank_s s_r;
    bank_s s_nxt;

    logic start_soft_reset_bit;
    logic start_en;
    logic start_sysop;
    logic soft_reset_bit_busy;
    logic en_busy;
    logic sysop_busy;
    logic soft_reset_bit_done;
    logic en_done;
    logic sysop_done;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Merge the strobed byte lanes of a write into the old value
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[8*i +: 8] = new_v[8*i +: 8];
        end
        return res;
    endfunction

    // Word address of a printed offset
    function automatic logic [5:0] word_of(input logic [5:0] ofs);
        return {ofs[5:2], 2'b00};
    endfunction

    // Registers under the peripheral guard
    function automatic logic guarded(input logic [5:0] wa);
        return (wa == word_of(OFS_CTRL_PRI)) ||
               (wa == word_of(OFS_CTRL_SEC)) ||
               (wa == word_of(OFS_BIT_RATE)) ||
               (wa == word_of(OFS_HALT));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Core-side delay trackers, one per synchronised operation

    sync_tracker #(.STAGES(SYNC_CYCLES)) u_soft_reset_bit (
        .clk(CLOCK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .start(start_soft_reset_bit),
        .busy(soft_reset_bit_busy),
        .done(soft_reset_bit_done)
    );

    sync_tracker #(.STAGES(SYNC_CYCLES)) u_enable (
        .clk(CLOCK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .start(start_en),
        .busy(en_busy),
        .done(en_done)
    );

    sync_tracker #(.STAGES(SYNC_CYCLES)) u_sysop (
        .clk(CLOCK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .start(start_sysop),
        .busy(sysop_busy),
        .done(sysop_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole bank
    always_comb
    begin
        logic setup;
        logic hit;
        logic err;
        logic master;
        logic enabled;
        logic [5:0] wa;
        logic [31:0] rd;
        logic [31:0] v;
        logic [7:0] irq_ok;
        logic [15:0] status;

        s_nxt = s_r;
        start_soft_reset_bit = 1'b0;
        start_en = 1'b0;
        start_sysop = 1'b0;
        setup = PSEL && !PENABLE;
        hit = 1'b1;
        err = 1'b0;
        v = '0;
        rd = '0;
        wa = word_of(PADDR);
        master = s_r.ctrl_pri[MODE_LSB +: MODE_W] == MODE_MASTER;
        // Either the written bit or the core state counts as enabled
        enabled = s_r.ctrl_pri[ENABLE_POS] || s_r.core_en;
        irq_ok = master ? IRQ_MASTER_MASK : IRQ_SLAVE_MASK;
        status = STATUS_IN;
        if (master)
            status[BUS_STATE_LSB +: 2] = s_r.bus_state;
        s_nxt.ready = 1'b0;
        s_nxt.slverr = 1'b0;

        // Core side follows the enable bit once the crossing ends; a soft reset clears it at once
        if (en_done)
            s_nxt.core_en = s_r.ctrl_pri[ENABLE_POS];

        // Hardware events set flags; a set in a clearing cycle survives
        s_nxt.pending = s_r.pending | (FLAG_EVENTS & irq_ok);

        // Read mux, the soft reset bit reads back as busy during a soft reset
        unique case (wa)
            word_of(OFS_CTRL_PRI):
            begin
                rd = s_r.ctrl_pri;
                rd[SOFT_RESET_POS] = soft_reset_bit_busy;
                rd[RSV_TOP_POS] = 1'b0;
            end
            word_of(OFS_CTRL_SEC): rd = s_r.ctrl_sec;
            word_of(OFS_BIT_RATE): rd = s_r.bit_rate;
            word_of(OFS_MASK_CLR): rd = {8'h00, s_r.irq_mask, 8'h00,
                                         s_r.irq_mask};
            word_of(OFS_PENDING): rd = {status, 8'h00, s_r.pending};
            word_of(OFS_XDOM_PEND): rd = {29'h0, sysop_busy, en_busy,
                                          soft_reset_bit_busy};
            word_of(OFS_TGT_ADDR): rd = s_r.tgt_addr;
            word_of(OFS_XFER_DATA): rd = {16'h0000, s_r.xfer_data};
            word_of(OFS_HALT): rd = {24'h00_0000, s_r.halt};
            default:
            begin
                rd = '0;
                hit = 1'b0;
            end
        endcase

        // Write path; byte strobes pick the lanes taken
        if (setup && PWRITE && hit)
        begin
            if (soft_reset_bit_busy)
                err = 1'b1; // Any write during a soft reset errors
            else if (GUARD_PROTECT && guarded(wa))
                err = 1'b1;
            else
            begin
                unique case (wa)
                    word_of(OFS_CTRL_PRI):
                    begin
                        if (PSTRB[0] && PWDATA[SOFT_RESET_POS])
                        begin
                            // Soft reset discards the rest of the write
                            start_soft_reset_bit = 1'b1;
                            s_nxt.ctrl_pri = CTRL_PRI_RESET;
                            s_nxt.ctrl_sec = CTRL_SEC_RESET;
                            s_nxt.bit_rate = BIT_RATE_RESET;
                            s_nxt.tgt_addr = TGT_ADDR_RESET;
                            s_nxt.xfer_data = XFER_DATA_RESET;
                            s_nxt.irq_mask = IRQ_MASK_RESET;
                            s_nxt.pending = PENDING_RESET;
                            s_nxt.bus_state = BUS_STATE_RESET;
                            s_nxt.core_en = 1'b0;
                        end
                        else
                        begin
                            v = merge_lanes(s_r.ctrl_pri, PWDATA,
                                            PSTRB);
                            // Mode written now decides the writable set
                            if (v[MODE_LSB +: MODE_W] == MODE_MASTER)
                                v = v & CTRL_PRI_MASTER_MASK;
                            else
                                v = v & CTRL_PRI_SLAVE_MASK;
                            v[SOFT_RESET_POS] = 1'b0;
                            // Only the enable bit passes while enabled
                            if (enabled)
                            begin
                                v = s_r.ctrl_pri;
                                // An unstrobed lane leaves enable alone
                                if (PSTRB[0])
                                    v[ENABLE_POS] = PWDATA[ENABLE_POS];
                            end
                            if (PSTRB[0])
                            begin
                                if (en_busy)
                                    err = 1'b1;
                                else
                                begin
                                    // Read back at once, core follows
                                    s_nxt.ctrl_pri = v;
                                    start_en = 1'b1;
                                end
                            end
                            else
                                s_nxt.ctrl_pri = v;
                        end
                    end
                    word_of(OFS_CTRL_SEC):
                    begin
                        v = merge_lanes(s_r.ctrl_sec, PWDATA, PSTRB);
                        // Acknowledge action and command stay writable
                        if (enabled)
                            v = (s_r.ctrl_sec & ~CTRL_SEC_FREE_MASK) |
                                (v & CTRL_SEC_FREE_MASK);
                        v = v & (master ? CTRL_SEC_MASTER_MASK :
                                 CTRL_SEC_SLAVE_MASK);
                        // Command bits are strobes and never stored
                        s_nxt.ctrl_sec = v & ~CTRL_SEC_CMD_MASK;
                    end
                    word_of(OFS_BIT_RATE):
                    begin
                        if (!enabled)
                            s_nxt.bit_rate = merge_lanes(s_r.bit_rate,
                                                         PWDATA,
                                                         PSTRB);
                    end
                    word_of(OFS_MASK_CLR):
                    begin
                        // Lane 0 clears mask bits, lane 2 sets them
                        v[7:0] = s_r.irq_mask;
                        if (PSTRB[0])
                            v[7:0] = v[7:0] & ~PWDATA[7:0];
                        if (PSTRB[2])
                            v[7:0] = v[7:0] | PWDATA[23:16];
                        s_nxt.irq_mask = v[7:0] & irq_ok;
                    end
                    word_of(OFS_PENDING):
                    begin
                        // Clear by writing one; a new event still wins
                        if (PSTRB[0])
                            s_nxt.pending = (s_r.pending & ~PWDATA[7:0]) |
                                            (FLAG_EVENTS & irq_ok);
                        if (PSTRB[2] && master)
                        begin
                            if (sysop_busy)
                                err = 1'b1;
                            else
                            begin
                                s_nxt.bus_state =
                                    PWDATA[16 + BUS_STATE_LSB +: 2];
                                start_sysop = 1'b1;
                            end
                        end
                    end
                    word_of(OFS_TGT_ADDR):
                    begin
                        if (master && sysop_busy)
                            err = 1'b1;
                        else
                        begin
                            v = merge_lanes(s_r.tgt_addr, PWDATA, PSTRB);
                            s_nxt.tgt_addr = v & (master ?
                                TGT_ADDR_MASTER_MASK : TGT_ADDR_SLAVE_MASK);
                            start_sysop = master;
                        end
                    end
                    word_of(OFS_XFER_DATA):
                    begin
                        if (master && sysop_busy)
                            err = 1'b1;
                        else
                        begin
                            v = merge_lanes({16'h0000, s_r.xfer_data},
                                            PWDATA, PSTRB);
                            s_nxt.xfer_data = v[15:0] & XFER_DATA_MASK;
                            start_sysop = master && (PSTRB[1:0] != 2'b00);
                        end
                    end
                    word_of(OFS_HALT):
                    begin
                        if (PSTRB[0])
                            s_nxt.halt = PWDATA[7:0] & HALT_MASK;
                    end
                    default:
                    begin
                        // Cross-domain pending is read only
                        v = '0;
                    end
                endcase
            end
        end

        // Answer in the access phase, one cycle after setup
        if (setup)
        begin
            s_nxt.ready = 1'b1;
            s_nxt.rdata = PWRITE ? 32'h0000_0000 : rd;
            s_nxt.slverr = err || !hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; a low clock enable freezes the whole bank
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            s_r.ctrl_pri <= CTRL_PRI_RESET;
            s_r.ctrl_sec <= CTRL_SEC_RESET;
            s_r.bit_rate <= BIT_RATE_RESET;
            s_r.tgt_addr <= TGT_ADDR_RESET;
            s_r.xfer_data <= XFER_DATA_RESET;
            s_r.irq_mask <= IRQ_MASK_RESET;
            s_r.pending <= PENDING_RESET;
            s_r.bus_state <= BUS_STATE_RESET;
            s_r.halt <= HALT_RESET;
            s_r.core_en <= 1'b0;
            s_r.rdata <= 32'h0000_0000;
            s_r.ready <= 1'b0;
            s_r.slverr <= 1'b0;
        end
        else if (CLK_EN)
            s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register
    assign PRDATA = s_r.rdata;
    assign PREADY = s_r.ready;
    assign PSLVERR = s_r.slverr;
    assign CORE_ENABLE = s_r.core_en;
    assign CONTROL_PRIMARY = s_r.ctrl_pri;
    assign CONTROL_SECONDARY = s_r.ctrl_sec;
    assign BIT_RATE = s_r.bit_rate;
    assign TARGET_ADDR = s_r.tgt_addr;
    assign TX_DATA = s_r.xfer_data;
    assign IRQ_MASK = s_r.irq_mask;
    assign IRQ_PENDING = s_r.pending;
    assign HALT_STOP = s_r.halt[0];

endmodule

// ---- regbank_properties.sv ----
`timescale 1ns/1ns
module regbank_properties
    import regbank_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [5:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic GUARD_PROTECT,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic CORE_ENABLE,
    input wire logic [31:0] CONTROL_PRIMARY,
    input wire logic [31:0] CONTROL_SECONDARY,
    input wire logic [31:0] TARGET_ADDR,
    input wire logic HALT_STOP
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    // Setup phases the bank actually takes
    wire logic take = PSEL && !PENABLE && CLK_EN;
    wire logic wr = take && PWRITE;
    wire logic ctl0 = wr && PADDR[5:2] == 4'h0 && PSTRB[0] && !GUARD_PROTECT;

    a_ready_answer: assert property (take |=> PREADY)
        else $error("no ready after setup");
    a_ready_pulse: assert property (PREADY && CLK_EN |=> !PREADY)
        else $error("ready held too long");
    a_unmapped_err: assert property (take && PADDR[5:2] == 4'h2
        |=> PSLVERR)
        else $error("reserved word gave no error");
    a_bit31_zero: assert property (!CONTROL_PRIMARY[RSV_TOP_POS])
        else $error("reserved top bit set");
    a_guard_blocks: assert property (wr && GUARD_PROTECT
        && PADDR[5:2] == 4'h1 |=> PSLVERR && $stable(CONTROL_SECONDARY))
        else $error("guarded write got through");
    a_enprot_drop: assert property (ctl0
        && CONTROL_PRIMARY[ENABLE_POS] && CORE_ENABLE
        && !PWDATA[SOFT_RESET_POS] |=> $stable(CONTROL_PRIMARY[31:2]))
        else $error("protected field changed while on");
    a_enable_sync: assert property ($rose(CORE_ENABLE)
        |-> $past(CONTROL_PRIMARY[ENABLE_POS], 3))
        else $error("core enabled too early");
    a_reset_value: assert property ($fell(SYS_RST)
        |-> CONTROL_PRIMARY == CTRL_PRI_RESET && !CORE_ENABLE)
        else $error("control not zero after reset");
    a_soft_reset: assert property (ctl0 && PWDATA[SOFT_RESET_POS]
        |=> TARGET_ADDR == TGT_ADDR_RESET && $stable(HALT_STOP)
        && CONTROL_PRIMARY[31:1] == 31'h0000_0000)
        else $error("soft reset incomplete");
endmodule

bind regbank regbank_properties regbank_properties_i (.CLOCK, .SYS_RST,
    .CLK_EN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
    .GUARD_PROTECT, .PREADY, .PSLVERR, .CORE_ENABLE, .CONTROL_PRIMARY,
    .CONTROL_SECONDARY, .TARGET_ADDR, .HALT_STOP);

// ---- engine_model.sv ----
`timescale 1ns/1ns
module engine_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic active,
    output logic [7:0] events,
    output logic [15:0] status
);
    logic [15:0] lfsr_r;

    // Bus traffic pattern; changes every cycle so stale bits never pass
    always_ff @(posedge clk)
    begin
        if (rst) lfsr_r <= 16'h00A5;
        else lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13]};
    end

    // A quiet bus raises no events
    assign events = active ? lfsr_r[7:0] : 8'h00;
    assign status = active ? lfsr_r : 16'h0000;
endmodule

// ---- regbank_tb.sv ----
`timescale 1ns/1ns
module regbank_tb
    import regbank_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic guard = 1'b0, traffic = 1'b0, err, pready, pslverr, core_en, halt;
    logic [5:0] paddr = 6'h00;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v, base;
    logic [31:0] ctl_pri, ctl_sec, tgt, brate, wd, seed = 32'h0000_0006;
    logic [7:0] events, pend, imask;
    logic [15:0] status, txd;
    int err_total = 0, checked = 0;

    regbank regbank_i (.CLOCK(clock), .SYS_RST(rst), .CLK_EN(clk_en),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .GUARD_PROTECT(guard),
        .FLAG_EVENTS(events), .STATUS_IN(status), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CORE_ENABLE(core_en),
        .CONTROL_PRIMARY(ctl_pri), .CONTROL_SECONDARY(ctl_sec),
        .BIT_RATE(brate), .TARGET_ADDR(tgt), .TX_DATA(txd), .IRQ_MASK(imask),
        .IRQ_PENDING(pend), .HALT_STOP(halt));
    engine_model engine_model_i (.clk(clock), .rst(rst), .active(traffic),
        .events(events), .status(status));

    initial
    begin
        forever #50 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    // Xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected word after a strobed write
    function automatic logic [31:0] merge(input logic [31:0] o,
        input logic [31:0] n, input logic [3:0] s);
        for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = n[8*i +: 8];
        return o;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One bus cycle; request held until ready is seen at an edge
    task automatic bus(input logic w, input logic [5:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(negedge clock);
        {psel, penable, pwrite, paddr, pwdata, pstrb} = {2'b10, w, a, d, s};
        @(negedge clock);
        penable = 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clock);
            if (pready === 1'b1) break;
            if (i == 8) check(1'b0, 1'b1);
            if (i == 8) give_verdict();
        end
        rd = prdata;
        err = pslverr;
        @(negedge clock);
        {psel, penable} = 2'b00;
    endtask

    // Poll the cross-domain pending word until it clears
    task automatic wait_idle();
        for (int i = 0; i < 20; i++)
        begin
            bus(1'b0, OFS_XDOM_PEND, 32'h0000_0000, 4'h0);
            if (rd === 32'h0000_0000) return;
        end
        check(rd, 32'h0000_0000);
        give_verdict();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        bus(1'b0, OFS_CTRL_PRI, 32'h0000_0000, 4'h0);
        check(rd, CTRL_PRI_RESET);
        bus(1'b1, OFS_HALT, 32'h0000_0001, 4'h1);
        // Random slave setups; the top bit is written high to see it dropped
        for (int i = 0; i < 4; i++)
        begin
            v = (rnd() & CTRL_PRI_SLAVE_MASK & ~32'h0000_0003) | 32'h8000_0000;
            v[MODE_LSB +: MODE_W] = MODE_SLAVE;
            bus(1'b1, OFS_CTRL_PRI, v, 4'hF);
            wait_idle();
            bus(1'b0, OFS_CTRL_PRI, 32'h0000_0000, 4'h0);
            v[RSV_TOP_POS] = 1'b0;
            check(rd, v);
        end
        // Every non-empty strobe mix; the bus task overwrites rd, so data sits in wd
        base = rnd() & TGT_ADDR_SLAVE_MASK;
        bus(1'b1, OFS_TGT_ADDR, base, 4'hF);
        for (int s = 1; s < 16; s++)
        begin
            wd = rnd();
            bus(1'b1, OFS_TGT_ADDR, wd, s[3:0]);
            base = merge(base, wd & TGT_ADDR_SLAVE_MASK, s[3:0]);
            bus(1'b0, OFS_TGT_ADDR, 32'h0000_0000, 4'h0);
            check(rd, base);
        end
        guard = 1'b1;
        bus(1'b1, OFS_CTRL_SEC, 32'hFFFF_FFFF, 4'hF);
        guard = 1'b0;
        check(err, 1'b1);
        check(ctl_sec, CTRL_SEC_RESET);
        bus(1'b0, 6'h08, 32'h0000_0000, 4'h0);
        check(err, 1'b1);
        // Enable, with the clock enable stalling the sync midway
        v[ENABLE_POS] = 1'b1;
        bus(1'b1, OFS_CTRL_PRI, v, 4'h1);
        clk_en = 1'b0;
        repeat (6) @(negedge clock);
        check(core_en, 1'b0);
        clk_en = 1'b1;
        bus(1'b1, OFS_CTRL_PRI, v, 4'h1);
        check(err, 1'b1);
        for (int i = 0; i < 8 && core_en !== 1'b1; i++) @(negedge clock);
        check(core_en, 1'b1);
        bus(1'b0, OFS_CTRL_PRI, 32'h0000_0000, 4'h0);
        check(rd, v);
        wait_idle();
        // Protected fields must hold while the interface runs
        bus(1'b1, OFS_CTRL_PRI, v ^ 32'h0030_0000, 4'hF);
        check(err, 1'b0);
        wait_idle();
        bus(1'b0, OFS_CTRL_PRI, 32'h0000_0000, 4'h0);
        check(rd, v);
        traffic = 1'b1;
        repeat (5) @(negedge clock);
        traffic = 1'b0;
        // Soft reset wins over the enable bit written with it
        bus(1'b1, OFS_CTRL_PRI, 32'h0000_0003, 4'h1);
        bus(1'b1, OFS_TGT_ADDR, 32'hFFFF_FFFF, 4'hF);
        check(err, 1'b1);
        wait_idle();
        check(ctl_pri, CTRL_PRI_RESET);
        check(tgt, TGT_ADDR_RESET);
        check({pend, core_en, halt}, 10'h001);
        // Disabled again: plain registers and their byte lanes
        wd = rnd();
        bus(1'b1, OFS_BIT_RATE, wd, 4'hF);
        check(brate, wd);
        bus(1'b1, OFS_XFER_DATA, wd, 4'h3);
        check(txd, wd[15:0] & XFER_DATA_MASK);
        bus(1'b1, OFS_MASK_SET, wd, 4'h4);
        check(imask, wd[23:16] & IRQ_SLAVE_MASK);
        bus(1'b1, OFS_MASK_CLR, wd, 4'h1);
        check(imask, wd[23:16] & ~wd[7:0] & IRQ_SLAVE_MASK);
        // Master mode: a second address write while syncing is refused
        bus(1'b1, OFS_CTRL_PRI, 32'(MODE_MASTER) << MODE_LSB, 4'h1);
        bus(1'b1, OFS_TGT_ADDR, wd, 4'hF);
        check(err, 1'b0);
        bus(1'b1, OFS_TGT_ADDR, ~wd, 4'hF);
        check(err, 1'b1);
        check(tgt, wd & TGT_ADDR_MASTER_MASK);
        wait_idle();
        give_verdict();
    end
endmodule
